// >>> tbp_map.vh
// Register map, field positions, reset values and timing for the PWM block.
`ifndef TBP_MAP_VH
`define TBP_MAP_VH
// ****************************************************************
// Register offsets
// ****************************************************************
`define TBP_IDX_CLK_CTRL 16'hffd0
`define TBP_IDX_DUTY_UP 16'hffd1
`define TBP_IDX_DUTY_LO 16'hffd2
`define TBP_IDX_P9_FUNC 16'hffec
`define TBP_IDX_PB_FUNC 16'hffee
`define TBP_IDX_EDGE_SEL 16'hfff2
`define TBP_IDX_IRQ_EN 16'hfff3
`define TBP_IDX_IRQ_REQ 16'hfff6
`define TBP_IDX_IRQ_STAT 16'hfff8
`define TBP_IDX_IRQ_MASK 16'hfff9
// ****************************************************************
// Field positions
// ****************************************************************
`define TBP_BIT_PWM_SEL 0
`define TBP_BIT_IRQ_SEL 3
`define TBP_BIT_EDGE 1
`define TBP_BIT_IEN 1
`define TBP_BIT_PEND 1
`define TBP_STAT_EDGE 0
`define TBP_STAT_LOAD 1
// ****************************************************************
// Reset values
// ****************************************************************
`define TBP_RST_BYTE 8'h00
`define TBP_RST_DUTY 10'h000
`define TBP_RST_STAT 2'h0
// ****************************************************************
// Timing
// ****************************************************************
`define TBP_PRESC_W 13
`define TBP_FRAME_W 10
`endif

// >>> tbp_pwm.v
// Ten-bit pulse-division PWM channel with edge interrupt and APB registers.
//
// Summary of operation
// - A 10-bit duty is held, upper 2 bits and lower 8 bits in two registers.
// - Both duty registers are write-only and read back as zero.
// - Writing the upper bits moves the full value into the generator.
// - The duty equals the high clock units in one 1024-unit period.
// - High time is spread over the period by pulse division.
// - The clock control register is eight-bit write-only, picking the clock.
// - Clock select bits 1:0 at zero clock the PWM from the system clock.
// - A 13-bit up-counting prescaler supplies the other clock choices.
// - Port-9 function bit 0 picks general output or PWM on the pin.
// - Port-B function bit 3 picks general input or the interrupt input.
// - Edge select bit 1 picks falling (0) or rising (1) edge.
// - Enable bit 1 gates the external interrupt request.
// - Request bit 1 reads one once the selected edge has been seen.
// - The port-9 function register is eight-bit read and write.
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/1ps
`include "tbp_map.vh"
module tbp_pwm (
    // Clock and reset
    input wire I_MCLK,
    input wire I_SYS_RST,
    // APB slave
    input wire I_PSEL,
    input wire I_PENABLE,
    input wire I_PWRITE,
    input wire [17:0] I_PADDR,
    input wire [31:0] I_PWDATA,
    output reg [31:0] O_PRDATA,
    output reg O_PREADY,
    output reg O_PSLVERR,
    // Pins
    input wire I_EXT_IRQ_PIN,
    input wire I_GENERAL_OUT_LEVEL,
    output reg O_PWM_PIN,
    output reg O_GENERAL_INPUT_PIN,
    output reg O_IRQ
);
// ****************************************************************
// Registers and bus decode
// ****************************************************************
reg [7:0] clk_ctrl_r;
reg [7:0] duty_lo_r;
reg [9:0] duty_r;
reg [7:0] p9_func_r;
reg [7:0] pb_func_r;
reg [7:0] edge_sel_r;
reg [7:0] irq_en_r;
reg pend_r;
reg [1:0] stat_r;
reg [1:0] mask_r;
reg [12:0] presc_r;
reg [9:0] frame_r;
reg tick_r;
reg pin_s1_r;
reg pin_s2_r;
reg pin_d_r;
reg load_pulse;
reg [31:0] rdata_nxt;
reg hit;
wire [15:0] idx;
wire wr_acc;
wire rd_acc;
wire edge_seen;
wire [9:0] rev;
wire [12:0] presc_nxt;
wire [1:0] sel;
reg tick_nxt;
wire [9:0] frame_nxt;
wire duty_hi;
wire acc_now;
wire edge_evt;
wire req_wr;
wire req_clr;
wire stat_wr;
wire [1:0] stat_clr;
wire [1:0] stat_set;
wire req_on;
wire stat_on;
// Registers sit one per word; the byte address is four times the index.
assign idx = I_PADDR[17:2];
assign acc_now = I_PSEL & I_PENABLE & ~O_PREADY;
assign wr_acc = I_PSEL & I_PENABLE & I_PWRITE & ~O_PREADY;
assign rd_acc = I_PSEL & I_PENABLE & ~I_PWRITE & ~O_PREADY;

always @* begin
    hit = 1'b1;
    rdata_nxt = 32'h00000000;
    case (idx)
        `TBP_IDX_DUTY_UP: begin
            rdata_nxt = 32'h00000000;
        end
        `TBP_IDX_DUTY_LO: begin
            rdata_nxt = 32'h00000000;
        end
        `TBP_IDX_CLK_CTRL: begin
            rdata_nxt = 32'h00000000;
        end
        `TBP_IDX_P9_FUNC: begin
            rdata_nxt = {24'h000000, p9_func_r};
        end
        `TBP_IDX_PB_FUNC: begin
            rdata_nxt = {24'h000000, pb_func_r};
        end
        `TBP_IDX_EDGE_SEL: begin
            rdata_nxt = {24'h000000, edge_sel_r};
        end
        `TBP_IDX_IRQ_EN: begin
            rdata_nxt = {24'h000000, irq_en_r};
        end
        `TBP_IDX_IRQ_REQ: begin
            rdata_nxt = {30'h00000000, pend_r, 1'b0};
        end
        `TBP_IDX_IRQ_STAT: begin
            rdata_nxt = {30'h00000000, stat_r};
        end
        `TBP_IDX_IRQ_MASK: begin
            rdata_nxt = {30'h00000000, mask_r};
        end
        default: begin
            hit = 1'b0;
        end
    endcase
end

// One wait state: the access is answered in the cycle after penable rises.
always @(posedge I_MCLK) begin
    if (I_SYS_RST) begin
        O_PREADY <= 1'b0;
        O_PRDATA <= 32'h00000000;
        O_PSLVERR <= 1'b0;
    end else begin
        // Strobes fire once, in the cycle before ready rises.
        O_PREADY <= acc_now;
        O_PSLVERR <= acc_now & ~hit;
        if (rd_acc) begin
            O_PRDATA <= rdata_nxt;
        end
    end
end

// ****************************************************************
// Register writes
// ****************************************************************
always @(posedge I_MCLK) begin
    if (I_SYS_RST) begin
        clk_ctrl_r <= `TBP_RST_BYTE;
        duty_lo_r <= `TBP_RST_BYTE;
        duty_r <= `TBP_RST_DUTY;
        p9_func_r <= `TBP_RST_BYTE;
        pb_func_r <= `TBP_RST_BYTE;
        edge_sel_r <= `TBP_RST_BYTE;
        irq_en_r <= `TBP_RST_BYTE;
        mask_r <= `TBP_RST_STAT;
        load_pulse <= 1'b0;
    end else begin
        load_pulse <= 1'b0;
        if (wr_acc) begin
            case (idx)
                `TBP_IDX_CLK_CTRL: begin
                    clk_ctrl_r <= I_PWDATA[7:0];
                end
                `TBP_IDX_DUTY_LO: begin
                    duty_lo_r <= I_PWDATA[7:0];
                end
                `TBP_IDX_DUTY_UP: begin
                    duty_r <= {I_PWDATA[1:0], duty_lo_r};
                    load_pulse <= 1'b1;
                end
                `TBP_IDX_P9_FUNC: begin
                    p9_func_r <= I_PWDATA[7:0];
                end
                `TBP_IDX_PB_FUNC: begin
                    pb_func_r <= I_PWDATA[7:0];
                end
                `TBP_IDX_EDGE_SEL: begin
                    edge_sel_r <= I_PWDATA[7:0];
                end
                `TBP_IDX_IRQ_EN: begin
                    irq_en_r <= I_PWDATA[7:0];
                end
                `TBP_IDX_IRQ_MASK: begin
                    mask_r <= I_PWDATA[1:0];
                end
                default: begin
                    mask_r <= mask_r;
                end
            endcase
        end
    end
end

// ****************************************************************
// Prescaler and PWM generator
// ****************************************************************
// prescaler count up
assign presc_nxt = presc_r + 13'h0001;
assign sel = clk_ctrl_r[1:0];
// select zero is system clock
// Each divided choice ticks when its prescaler bit rises.
always @* begin
    tick_nxt = 1'b0;
    case (sel)
        2'b00: begin
            tick_nxt = 1'b1;
        end
        2'b01: begin
            tick_nxt = presc_nxt[0] & ~presc_r[0];
        end
        2'b10: begin
            tick_nxt = presc_nxt[1] & ~presc_r[1];
        end
        2'b11: begin
            tick_nxt = presc_nxt[2] & ~presc_r[2];
        end
        default: begin
            tick_nxt = 1'b1;
        end
    endcase
end
assign frame_nxt = frame_r + 10'h001;
// Bit-reversed frame count spreads high units evenly across the period.
genvar gi;
generate
    for (gi = 0; gi < `TBP_FRAME_W; gi = gi + 1) begin : g_rev
        assign rev[gi] = frame_r[`TBP_FRAME_W - 1 - gi];
    end
endgenerate
// A duty of all ones leaves one unit low; full on is not reachable.
assign duty_hi = (rev < duty_r);

always @(posedge I_MCLK) begin
    if (I_SYS_RST) begin
        presc_r <= 13'h0000;
        tick_r <= 1'b0;
        frame_r <= 10'h000;
        O_PWM_PIN <= 1'b0;
    end else begin
        presc_r <= presc_nxt;
        tick_r <= tick_nxt;
        if (tick_r) begin
            frame_r <= frame_nxt;
        end
        if (p9_func_r[`TBP_BIT_PWM_SEL]) begin
            O_PWM_PIN <= duty_hi;
        end else begin
            O_PWM_PIN <= I_GENERAL_OUT_LEVEL;
        end
    end
end

// ****************************************************************
// External interrupt
// ****************************************************************
// edge polarity choose
assign edge_seen = edge_sel_r[`TBP_BIT_EDGE] ? (pin_s2_r & ~pin_d_r) :
                   (~pin_s2_r & pin_d_r);
assign edge_evt = pb_func_r[`TBP_BIT_IRQ_SEL] & edge_seen;
assign req_wr = wr_acc & (idx == `TBP_IDX_IRQ_REQ);
assign req_clr = req_wr & ~I_PWDATA[`TBP_BIT_PEND];
assign stat_wr = wr_acc & (idx == `TBP_IDX_IRQ_STAT);
assign stat_clr = stat_wr ? I_PWDATA[1:0] : 2'b00;
assign stat_set = {load_pulse, edge_evt};
assign req_on = pend_r & irq_en_r[`TBP_BIT_IEN];
assign stat_on = |(stat_r & mask_r);

// ****************************************************************
// Pin synchroniser
// ****************************************************************
// The pin is asynchronous; only the second stage and its delayed copy feed any logic.
always @(posedge I_MCLK) begin
    if (I_SYS_RST) begin
        pin_s1_r <= 1'b0;
        pin_s2_r <= 1'b0;
        pin_d_r <= 1'b0;
    end else begin
        pin_s1_r <= I_EXT_IRQ_PIN;
        pin_s2_r <= pin_s1_r;
        pin_d_r <= pin_s2_r;
    end
end

// ****************************************************************
// General input pin
// ****************************************************************
always @(posedge I_MCLK) begin
    if (I_SYS_RST) begin
        O_GENERAL_INPUT_PIN <= 1'b0;
    end else begin
        if (pb_func_r[`TBP_BIT_IRQ_SEL]) begin
            O_GENERAL_INPUT_PIN <= 1'b0;
        end else begin
            O_GENERAL_INPUT_PIN <= pin_s2_r;
        end
    end
end

// ****************************************************************
// Request flag
// ****************************************************************
// A clear that meets a new edge in the same cycle loses, so none is lost.
always @(posedge I_MCLK) begin
    if (I_SYS_RST) begin
        pend_r <= 1'b0;
    end else begin
        if (edge_evt) begin
            pend_r <= 1'b1;
        end else if (req_clr) begin
            pend_r <= 1'b0;
        end
    end
end

// ****************************************************************
// Sticky status and interrupt line
// ****************************************************************
// Status clears by writing one; a new event in the same cycle still wins.
always @(posedge I_MCLK) begin
    if (I_SYS_RST) begin
        stat_r <= `TBP_RST_STAT;
        O_IRQ <= 1'b0;
    end else begin
        stat_r <= (stat_r & ~stat_clr) | stat_set;
        O_IRQ <= req_on | stat_on;
    end
end

endmodule

// >>> tbp_pwm_props.sv
// Port checks for the PWM block.
`timescale 1ns/1ps
`include "tbp_map.vh"
// ****
// Checker
// ****
module tbp_pwm_chk (
    // Inputs seen
    input wire I_MCLK,
    input wire I_SYS_RST,
    input wire I_PSEL,
    input wire I_PENABLE,
    input wire I_PWRITE,
    input wire [17:0] I_PADDR,
    // Outputs seen
    input wire [31:0] O_PRDATA,
    input wire O_PREADY,
    input wire O_PSLVERR,
    input wire O_PWM_PIN,
    input wire O_IRQ
);
    localparam [15:0] IU = `TBP_IDX_DUTY_UP;
    localparam [15:0] IL = `TBP_IDX_DUTY_LO;
    localparam [15:0] IC = `TBP_IDX_CLK_CTRL;
    wire rd_now = O_PREADY && !I_PWRITE;
    wire hit_d = I_PADDR[17:2] == IU || I_PADDR[17:2] == IL;
    wire hit_c = I_PADDR[17:2] == IC;
    default clocking @(posedge I_MCLK); endclocking
    default disable iff (I_SYS_RST);
    property p_wait; I_PSEL && I_PENABLE && !O_PREADY |=> O_PREADY; endproperty
    a_wait: assert property (p_wait) else $error("ready late");
    property p_pulse; O_PREADY |=> !O_PREADY; endproperty
    a_pulse: assert property (p_pulse) else $error("ready long");
    property p_cause; O_PREADY |-> $past(I_PSEL && I_PENABLE); endproperty
    a_cause: assert property (p_cause) else $error("ready unasked");
    property p_err; O_PSLVERR |-> O_PREADY; endproperty
    a_err: assert property (p_err) else $error("error alone");
    property p_hold; !rd_now |-> $stable(O_PRDATA); endproperty
    a_hold: assert property (p_hold) else $error("read data moved");
    property p_duty; rd_now && hit_d |-> O_PRDATA == 32'h0; endproperty
    a_duty: assert property (p_duty) else $error("duty readable");
    property p_ctrl; rd_now && hit_c |-> O_PRDATA == 32'h0; endproperty
    a_ctrl: assert property (p_ctrl) else $error("ctrl readable");
    property p_rst; $past(I_SYS_RST) |-> !O_IRQ && !O_PWM_PIN; endproperty
    a_rst: assert property (p_rst) else $error("not quiet");
endmodule
bind tbp_pwm tbp_pwm_chk chk_u(.I_MCLK(I_MCLK), .I_SYS_RST(I_SYS_RST),
    .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE),
    .I_PADDR(I_PADDR), .O_PRDATA(O_PRDATA), .O_PREADY(O_PREADY),
    .O_PSLVERR(O_PSLVERR), .O_PWM_PIN(O_PWM_PIN), .O_IRQ(O_IRQ));

// >>> tbp_motor.sv
// Transistor load and push-button model.
`timescale 1ns/1ps
module tbp_motor (
    input wire i_clk,
    input wire i_drive,
    output logic o_button
);
    initial o_button = 1'b0;
    task automatic press(input logic lvl);
        @(posedge i_clk);
        o_button <= lvl;
    endtask
    // Counts whole periods, so the phase of the start does not matter.
    task automatic measure(input int n, output int hi, output int ed);
        logic prv;
        hi = 0;
        ed = 0;
        prv = 1'b1;
        repeat (n) begin
            @(negedge i_clk);
            if (i_drive === 1'b1) hi++;
            if (i_drive === 1'b1 && !prv) ed++;
            prv = (i_drive === 1'b1);
        end
    endtask
endmodule

// >>> tb_top.sv
// Self-checking bench for the PWM block.
`timescale 1ns/1ps
`include "tbp_map.vh"
`define CK(g, e) begin num_checks++; if ((g) !== (e)) begin failures++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top;
    logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, gol = 0, er;
    logic [17:0] padr = 0;
    logic [31:0] pwd = 0, rd;
    wire [31:0] prd;
    wire prdy, perr, pwm, gin, irq, btn;
    int failures = 0, num_checks = 0, cyc = 0, hi, ed;
    always #2.5 clk = ~clk;
    tbp_pwm dut_u(.I_MCLK(clk), .I_SYS_RST(rst), .I_PSEL(psel),
        .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(padr), .I_PWDATA(pwd),
        .O_PRDATA(prd), .O_PREADY(prdy), .O_PSLVERR(perr),
        .I_EXT_IRQ_PIN(btn), .I_GENERAL_OUT_LEVEL(gol), .O_PWM_PIN(pwm),
        .O_GENERAL_INPUT_PIN(gin), .O_IRQ(irq));
    tbp_motor m_u(.i_clk(clk), .i_drive(pwm), .o_button(btn));
    task apb(input logic w, input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        psel <= 1;
        pwr <= w;
        padr <= {a, 2'b00};
        pwd <= {24'h0, d};
        @(posedge clk);
        pen <= 1;
        do @(posedge clk); while (prdy !== 1'b1);
        rd = prd;
        er = perr;
        psel <= 0;
        pen <= 0;
    endtask
    task wt(input int n);
        repeat (n) @(negedge clk);
    endtask
    // One frame and eight cycles to settle, then one whole frame counted.
    task meas(input int n);
        wt(n + 8);
        m_u.measure(n, hi, ed);
    endtask
    task t_regs;
        apb(1, `TBP_IDX_P9_FUNC, 8'h5a);
        apb(0, `TBP_IDX_P9_FUNC, 8'h00);
        `CK(rd[7:0], 8'h5a)
        apb(1, `TBP_IDX_CLK_CTRL, 8'hfc);
        apb(1, `TBP_IDX_DUTY_LO, 8'h12);
        apb(0, `TBP_IDX_DUTY_LO, 8'h00);
        `CK(rd, 32'h0)
        apb(0, `TBP_IDX_CLK_CTRL, 8'h00);
        `CK(rd, 32'h0)
        apb(0, 16'h0100, 8'h00);
        `CK(er, 1'b1)
        gol <= 1;
        m_u.press(1);
        wt(8);
        `CK(pwm, 1'b1)
        `CK(gin, 1'b1)
        m_u.press(0);
    endtask
    task t_pwm;
        apb(1, `TBP_IDX_P9_FUNC, 8'h01);
        apb(1, `TBP_IDX_DUTY_LO, 8'h80);
        apb(1, `TBP_IDX_DUTY_UP, 8'h03);
        meas(1024);
        `CK(hi, 896)
        `CK(ed > 4, 1'b1)
        apb(1, `TBP_IDX_DUTY_LO, 8'hff);
        meas(1024);
        `CK(hi, 896)
        apb(1, `TBP_IDX_DUTY_UP, 8'h03);
        meas(1024);
        `CK(hi, 1023)
        apb(1, `TBP_IDX_CLK_CTRL, 8'h01);
        meas(2048);
        `CK(hi, 2046)
        apb(1, `TBP_IDX_CLK_CTRL, 8'h02);
        meas(4096);
        `CK(hi, 4092)
        apb(1, `TBP_IDX_CLK_CTRL, 8'h03);
        meas(8192);
        `CK(hi, 8184)
    endtask
    task t_irq;
        apb(1, `TBP_IDX_PB_FUNC, 8'h08);
        apb(1, `TBP_IDX_EDGE_SEL, 8'h02);
        apb(1, `TBP_IDX_IRQ_EN, 8'h02);
        apb(1, `TBP_IDX_IRQ_REQ, 8'h00);
        m_u.press(1);
        wt(10);
        `CK(gin, 1'b0)
        `CK(irq, 1'b1)
        apb(0, `TBP_IDX_IRQ_REQ, 8'h00);
        `CK(rd[1], 1'b1)
        apb(1, `TBP_IDX_IRQ_REQ, 8'h00);
        m_u.press(0);
        wt(10);
        `CK(irq, 1'b0)
        apb(0, `TBP_IDX_IRQ_REQ, 8'h00);
        `CK(rd[1], 1'b0)
        apb(1, `TBP_IDX_IRQ_EN, 8'h00);
        m_u.press(1);
        wt(10);
        `CK(irq, 1'b0)
        apb(1, `TBP_IDX_IRQ_MASK, 8'h01);
        wt(2);
        `CK(irq, 1'b1)
        apb(1, `TBP_IDX_IRQ_STAT, 8'h03);
        wt(2);
        `CK(irq, 1'b0)
    endtask
    task complete_run;
        $display("checks=%0d failures=%0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 60000) begin
            failures++;
            complete_run;
        end
    end
    initial begin
        repeat (6) @(posedge clk);
        rst <= 0;
        t_regs;
        t_pwm;
        t_irq;
        complete_run;
    end
endmodule
